// File: usb_port_route_pkg.sv
// Purpose: Shared types and constants for the host port routing block
// Assumes: Three host ports plus one OTG port; port 3 is index 2
// Notes: Mode codes are one-hot so illegal mixes decode cleanly
package usb_port_route_pkg;

    // ------------------------------------------------------------------
    // Port modes and owners
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SERIAL = 3'b001,
        MODE_TLL = 3'b010,
        MODE_ULPI_PHY = 3'b100
    } port_mode_t;

    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_HS = 2'b01,
        OWN_FS = 2'b10
    } owner_t;

    localparam int NUM_PORTS = 3;
    localparam int NO_PHY_PORT = 2;
    localparam int ULPI_DATA_W = 8;
    localparam int ULPI_PINS = 12;
    localparam int HS_RATE_MBPS = 480;
    localparam int FS_RATE_KBPS = 12000;
    localparam int LS_RATE_KBPS = 1500;
    localparam int CLK_PERIOD_NS = 4;
    // Link clock divider: half period of generated ULPI clock in cycles
    localparam int LINK_HALF_NS = 8;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ULPI pin group toward an external transceiver
    typedef struct packed {
        logic [7:0] data;
        logic dir;
        logic nxt;
    } ulpi_in_t;

    typedef struct packed {
        logic [7:0] data;
        logic data_oe_b;
        logic stp;
    } ulpi_out_t;

endpackage : usb_port_route_pkg

// File: usb_host_port_ownership_mux.sv
// Purpose: Port ownership, mode routing and ULPI link steering
// Assumes: Mode configuration arrives as plain inputs, static in use
// Notes: One design file; link clock of OTG port sampled from the pin
//
// Summary of operation
// R1: Each enabled host port with a legal mode is owned by exactly one host controller.
// R2: The high-speed controller carries 480 Mbit/s traffic over UTMI or ULPI.
// R3: The full/low-speed controller carries 12/1.5 Mbit/s over a serial link.
// R4: Both controllers run at once, each on its own ports, with no stall.
// R5: A UTMI-side port is converted to transceiver-less ULPI toward the far side.
// R6: Software must give every port the same mode family once any uses ULPI.
// R7: Port 3 may only be serial or transceiver-less, never external-PHY ULPI.
// R8: On ports 1 and 2 with an external PHY the controller sources the link clock.
// R9: An external-PHY port carries only high-speed traffic, via a hub for slower.
// R10: The OTG port uses a 12-pin ULPI link with an 8-bit single-rate data path.
// R11: The OTG port's PHY makes the link clock itself for the controller.
// R12: Mixed modes or port 3 in external-PHY mode flag an error and disable the port.
`timescale 1ns/1ps
`default_nettype none
module usb_host_port_ownership_mux #(
    parameter int NPORT = usb_port_route_pkg::NUM_PORTS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration
    input wire logic [NPORT-1:0] port_en,
    input wire usb_port_route_pkg::port_mode_t port_mode [NPORT],
    // Controller side, per port
    input wire logic [NPORT-1:0] hs_tx_valid,
    input wire logic [7:0] hs_tx_data [NPORT],
    input wire logic [NPORT-1:0] fs_tx_valid,
    input wire logic [NPORT-1:0] fs_tx_bit,
    // Far side, per port (ULPI pins, or TLL link)
    input wire usb_port_route_pkg::ulpi_in_t port_ulpi_in [NPORT],
    output usb_port_route_pkg::ulpi_out_t port_ulpi_out [NPORT],
    output logic [NPORT-1:0] port_clk_out,
    output logic [NPORT-1:0] port_serial_out,
    // Status
    output usb_port_route_pkg::owner_t port_owner [NPORT],
    output logic [NPORT-1:0] port_active,
    output logic cfg_error,
    // OTG ULPI link, clock from the PHY
    input wire logic otg_link_clk,
    input wire usb_port_route_pkg::ulpi_in_t otg_ulpi_in,
    input wire logic otg_tx_valid,
    input wire logic [7:0] otg_tx_data,
    output usb_port_route_pkg::ulpi_out_t otg_ulpi_out,
    output logic [7:0] otg_rx_data,
    output logic otg_rx_valid
);
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // Configuration check
    // ------------------------------------------------------------------
    logic any_ulpi, any_other, mixed;
    logic [NPORT-1:0] bad_d, bad_q;
    usb_port_route_pkg::owner_t owner_d [NPORT];
    usb_port_route_pkg::owner_t owner_q [NPORT];

    // Mode family clash across enabled ports
    always_comb
    begin
        any_ulpi = 1'b0;
        any_other = 1'b0;
        for (int i = 0; i < NPORT; i++)
        begin
            if (port_en[i] && port_mode[i] == usb_port_route_pkg::MODE_ULPI_PHY)
                any_ulpi = 1'b1;
            if (port_en[i] && port_mode[i] != usb_port_route_pkg::MODE_ULPI_PHY)
                any_other = 1'b1;
        end
        mixed = any_ulpi && any_other; // see R6
        // Owner per port; bad ports stay unowned and idle
        for (int i = 0; i < NPORT; i++)
        begin
            bad_d[i] = port_en[i] && (mixed ||
                ((i == usb_port_route_pkg::NO_PHY_PORT) &&
                 port_mode[i] == usb_port_route_pkg::MODE_ULPI_PHY)); // see R7, R12
            if (!port_en[i] || bad_d[i])
                owner_d[i] = usb_port_route_pkg::OWN_NONE;
            else if (port_mode[i] == usb_port_route_pkg::MODE_SERIAL)
                owner_d[i] = usb_port_route_pkg::OWN_FS; // see R3
            else
                owner_d[i] = usb_port_route_pkg::OWN_HS; // see R1, R2
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bad_q <= '0;
            for (int i = 0; i < NPORT; i++)
                owner_q[i] <= usb_port_route_pkg::OWN_NONE;
        end
        else
        begin
            bad_q <= bad_d;
            owner_q <= owner_d;
        end
    end

    // ------------------------------------------------------------------
    // Link clock divider for external-PHY ports
    // ------------------------------------------------------------------
    logic [3:0] div_d, div_q;
    logic lclk_d, lclk_q;

    // Divider; runs always so every PHY port sees one shared clock
    always_comb
    begin
        if (div_q == 4'(usb_port_route_pkg::LINK_HALF_CYC - 1))
        begin
            div_d = '0;
            lclk_d = ~lclk_q;
        end
        else
        begin
            div_d = div_q + 4'd1;
            lclk_d = lclk_q;
        end
    end

    // ------------------------------------------------------------------
    // Per-port data steering, registered
    // ------------------------------------------------------------------
    usb_port_route_pkg::ulpi_out_t pout_d [NPORT];
    usb_port_route_pkg::ulpi_out_t pout_q [NPORT];
    logic [NPORT-1:0] ser_d, ser_q;

    // Each port reads only its own owner, so controllers never contend
    always_comb
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            pout_d[i] = '{data: 8'h00, data_oe_b: 1'b1, stp: 1'b0};
            ser_d[i] = 1'b0;
            if (owner_q[i] == usb_port_route_pkg::OWN_HS && hs_tx_valid[i]
                && !port_ulpi_in[i].dir)
            begin
                pout_d[i].data = hs_tx_data[i]; // see R5, R9
                pout_d[i].data_oe_b = 1'b0;
            end
            if (owner_q[i] == usb_port_route_pkg::OWN_FS && fs_tx_valid[i])
                ser_d[i] = fs_tx_bit[i]; // see R3, R4
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ser_q <= '0;
            div_q <= '0;
            lclk_q <= 1'b0;
            for (int i = 0; i < NPORT; i++)
                pout_q[i] <= '{data: 8'h00, data_oe_b: 1'b1, stp: 1'b0};
        end
        else
        begin
            ser_q <= ser_d;
            div_q <= div_d;
            lclk_q <= lclk_d;
            pout_q <= pout_d;
        end
    end

    // Outputs; clock only on ports 1 and 2 in external-PHY mode
    always_comb
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            port_owner[i] = owner_q[i];
            port_active[i] = owner_q[i] != usb_port_route_pkg::OWN_NONE;
            port_ulpi_out[i] = pout_q[i];
            port_clk_out[i] = lclk_q && owner_q[i] == usb_port_route_pkg::OWN_HS
                && port_mode[i] == usb_port_route_pkg::MODE_ULPI_PHY; // see R8
        end
        port_serial_out = ser_q;
        cfg_error = |bad_q; // see R12
    end

    // ------------------------------------------------------------------
    // OTG ULPI link, registered on clk and stepped by sampled rises of the PHY's own clock
    // ------------------------------------------------------------------
    logic [2:0] lk_d, lk_q;
    logic lk_rise;
    usb_port_route_pkg::ulpi_in_t oin_s1_q, oin_s2_q;
    usb_port_route_pkg::ulpi_out_t oout_d, oout_q;
    logic [7:0] orx_d, orx_q;
    logic orxv_d, orxv_q;

    // Clock edge finder; stage 0 feeds only stage 1
    always_comb
    begin
        lk_d = {lk_q[1:0], otg_link_clk}; // see R11
        lk_rise = lk_q[1] && !lk_q[2];
    end

    // Capture on PHY clock rise; 8-bit single-rate data both ways
    always_comb
    begin
        oout_d = oout_q;
        orx_d = orx_q;
        orxv_d = 1'b0;
        if (lk_rise)
        begin
            if (oin_s2_q.dir)
            begin
                oout_d.data_oe_b = 1'b1;
                orx_d = oin_s2_q.data; // see R10
                orxv_d = 1'b1;
            end
            else
            begin
                oout_d.data_oe_b = !otg_tx_valid;
                oout_d.data = otg_tx_valid ? otg_tx_data : 8'h00; // see R10
            end
            oout_d.stp = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            lk_q <= '0;
            oin_s1_q <= '0;
            oin_s2_q <= '0;
            oout_q <= '{data: 8'h00, data_oe_b: 1'b1, stp: 1'b0};
            orx_q <= '0;
            orxv_q <= 1'b0;
        end
        else
        begin
            lk_q <= lk_d;
            oin_s1_q <= otg_ulpi_in;
            oin_s2_q <= oin_s1_q;
            oout_q <= oout_d;
            orx_q <= orx_d;
            orxv_q <= orxv_d;
        end
    end

    assign otg_ulpi_out = oout_q;
    assign otg_rx_data = orx_q;
    assign otg_rx_valid = orxv_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_one_owner;
        port_en[0] && !bad_d[0] |=> port_owner[0] != usb_port_route_pkg::OWN_NONE;
    endproperty
    a_one_owner: assert property (p_one_owner) else $error("enabled port unowned"); // see R1
    property p_port3_no_phy;
        port_en[2] && port_mode[2] == usb_port_route_pkg::MODE_ULPI_PHY |=> cfg_error
            && !port_active[2];
    endproperty
    a_port3_no_phy: assert property (p_port3_no_phy) else $error("port 3 PHY accepted"); // see R7
    property p_mixed_err;
        mixed |=> cfg_error ##0 port_active == '0;
    endproperty
    a_mixed_err: assert property (p_mixed_err) else $error("mixed modes accepted"); // see R12
    property p_fs_serial;
        port_owner[1] == usb_port_route_pkg::OWN_FS |-> port_ulpi_out[1].data_oe_b;
    endproperty
    a_fs_serial: assert property (p_fs_serial) else $error("FS port drove ULPI"); // see R3
    property p_hs_tx;
        owner_q[0] == usb_port_route_pkg::OWN_HS && hs_tx_valid[0] && !port_ulpi_in[0].dir
            |=> port_ulpi_out[0].data == $past(hs_tx_data[0]);
    endproperty
    a_hs_tx: assert property (p_hs_tx) else $error("HS data not passed"); // see R2, R5
    property p_parallel;
        owner_q[1] == usb_port_route_pkg::OWN_FS && fs_tx_valid[1]
            |=> port_serial_out[1] == $past(fs_tx_bit[1]);
    endproperty
    a_parallel: assert property (p_parallel) else $error("FS stalled"); // see R4
    property p_clk_gate;
        port_mode[2] != usb_port_route_pkg::MODE_ULPI_PHY |-> !port_clk_out[2]
            && !(port_clk_out[0] && owner_q[0] != usb_port_route_pkg::OWN_HS);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("link clock misrouted"); // see R8, R9
    sequence s_rx_edge;
        lk_rise && oin_s2_q.dir;
    endsequence
    property p_otg_rx;
        s_rx_edge |=> otg_rx_valid && otg_rx_data == $past(oin_s2_q.data) ##1 !otg_rx_valid;
    endproperty
    a_otg_rx: assert property (p_otg_rx) else $error("OTG receive wrong"); // see R10

endmodule : usb_host_port_ownership_mux
`default_nettype wire

// File: ulpi_phy_model.sv
// Purpose: Transceiver model on the far side of the OTG link
// Assumes: The transceiver makes its link clock all the time
// Notes: Data lines it has released show a changing pattern
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_model (
    // Link pins toward the block
    output logic link_clk,
    output usb_port_route_pkg::ulpi_in_t pins
);
    // ------------------------------------------
    // Link clock
    // ------------------------------------------
    // Made here, 64 ns period, phase unrelated to clk
    initial
    begin
        link_clk = 1'b0;
        pins = '0;
        #3;
        forever #32 link_clk = ~link_clk;
    end

    // Released bus never holds its last value
    always @(posedge link_clk)
        if (!pins.dir)
            pins.data <= pins.data + 8'h3b;

    // One received byte, held across a whole rise, 8-bit path
    task automatic send(input logic [7:0] b);
        @(negedge link_clk);
        pins = '{data: b, dir: 1'b1, nxt: 1'b1};
        @(negedge link_clk);
        pins.dir = 1'b0;
        pins.nxt = 1'b0;
    endtask : send
endmodule : ulpi_phy_model
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the host port routing block
// Assumes: Config changes only between traffic bursts
// Notes: Port 0 bytes and OTG receive bytes go through queues
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk;
    logic rst_b;
    logic [2:0] port_en;
    usb_port_route_pkg::port_mode_t mode [3];
    logic [2:0] hs_v;
    logic [7:0] hs_d [3];
    logic [2:0] fs_v;
    logic [2:0] fs_b;
    usb_port_route_pkg::ulpi_in_t p_in [3];
    usb_port_route_pkg::ulpi_out_t p_out [3];
    logic [2:0] pclk;
    logic [2:0] ser;
    usb_port_route_pkg::owner_t own [3];
    logic [2:0] act;
    logic cfg_err;
    logic otg_clk;
    usb_port_route_pkg::ulpi_in_t otg_in;
    logic otg_v;
    logic [7:0] otg_d;
    usb_port_route_pkg::ulpi_out_t otg_out;
    logic [7:0] rx_d;
    logic rx_v;
    int mismatches = 0;
    int checks = 0;
    logic [31:0] seed = 32'h2e36_fbe2;
    logic [7:0] hs_q [$];
    logic [7:0] rx_q [$];

    // ------------------------------------------
    // Clock, parts and helpers
    // ------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    usb_host_port_ownership_mux dut (.clk(clk), .rst_b(rst_b), .port_en(port_en),
        .port_mode(mode), .hs_tx_valid(hs_v), .hs_tx_data(hs_d), .fs_tx_valid(fs_v),
        .fs_tx_bit(fs_b), .port_ulpi_in(p_in), .port_ulpi_out(p_out), .port_clk_out(pclk),
        .port_serial_out(ser), .port_owner(own), .port_active(act), .cfg_error(cfg_err),
        .otg_link_clk(otg_clk), .otg_ulpi_in(otg_in), .otg_tx_valid(otg_v),
        .otg_tx_data(otg_d), .otg_ulpi_out(otg_out), .otg_rx_data(rx_d),
        .otg_rx_valid(rx_v));

    ulpi_phy_model phy (.link_clk(otg_clk), .pins(otg_in));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic chk(input int p, input usb_port_route_pkg::owner_t o, input logic a);
        cmp("owner", 8'(o), 8'(own[p]));
        cmp("active", 8'(a), 8'(act[p]));
    endtask : chk

    task automatic end_sim();
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // Any byte that shows up unannounced pops an unknown and fails
    always @(posedge clk)
    begin
        #2;
        if (p_out[0].data_oe_b === 1'b0)
            cmp("hs byte", hs_q.size() ? hs_q.pop_front() : 8'hxx, p_out[0].data);
        if (rx_v === 1'b1)
            cmp("otg rx", rx_q.size() ? rx_q.pop_front() : 8'hxx, rx_d);
    end

    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial
    begin
        logic [31:0] b;
        int n;
        int n2;
        logic prev;
        rst_b = 1'b0;
        port_en = 3'b000;
        mode = '{3{usb_port_route_pkg::MODE_SERIAL}};
        hs_v = 3'b000;
        hs_d = '{3{8'h00}};
        fs_v = 3'b000;
        fs_b = 3'b000;
        p_in = '{default: '0};
        otg_v = 1'b0;
        otg_d = 8'h00;
        step(16);
        cmp("cfg_error", 8'h00, 8'(cfg_err));
        chk(0, usb_port_route_pkg::OWN_NONE, 1'b0);
        rst_b = 1'b1;
        // All serial: the slow controller owns every port
        port_en = 3'b111;
        step(2);
        for (int p = 0; p < 3; p++)
            chk(p, usb_port_route_pkg::OWN_FS, 1'b1);
        // TLL port 0 carries bytes while ports 1 and 2 shift bits
        mode[0] = usb_port_route_pkg::MODE_TLL;
        step(2);
        cmp("cfg_error", 8'h00, 8'(cfg_err));
        repeat (16)
        begin
            b = rnd();
            fs_v = 3'b110;
            fs_b = {b[1:0], 1'b0};
            hs_v = 3'b001;
            hs_d[0] = b[15:8];
            hs_q.push_back(b[15:8]);
            step(1);
            cmp("serial", 8'({b[1:0], 1'b0}), 8'(ser));
        end
        hs_v = 3'b000;
        fs_v = 3'b000;
        // External transceiver mode, port 3 asked for it too
        mode = '{3{usb_port_route_pkg::MODE_ULPI_PHY}};
        step(2);
        cmp("cfg_error", 8'h01, 8'(cfg_err));
        chk(0, usb_port_route_pkg::OWN_HS, 1'b1);
        chk(1, usb_port_route_pkg::OWN_HS, 1'b1);
        chk(2, usb_port_route_pkg::OWN_NONE, 1'b0);
        n = 0;
        n2 = 0;
        repeat (16)
        begin
            prev = pclk[0];
            step(1);
            n += (pclk[0] === 1'b1 && prev === 1'b0) ? 1 : 0;
            n2 += (pclk[2] !== 1'b0 || pclk[1] !== pclk[0]) ? 1 : 0;
        end
        cmp("link clk rises", 8'(16 / (2 * usb_port_route_pkg::LINK_HALF_CYC)), 8'(n));
        cmp("clk spread", 8'h00, 8'(n2));
        port_en = 3'b011;
        step(2);
        cmp("cfg_error", 8'h00, 8'(cfg_err));
        // Back-to-back bytes, then one refused while the far side drives
        for (int i = 0; i < 9; i++)
        begin
            b = rnd();
            hs_v = 3'b001;
            hs_d[0] = b[7:0];
            p_in[0].dir = (i == 8);
            if (i < 8)
                hs_q.push_back(b[7:0]);
            step(1);
        end
        hs_v = 3'b000;
        p_in[0].dir = 1'b0;
        // One port falls back to serial: mixed families shut both
        mode[1] = usb_port_route_pkg::MODE_SERIAL;
        step(2);
        cmp("cfg_error", 8'h01, 8'(cfg_err));
        chk(0, usb_port_route_pkg::OWN_NONE, 1'b0);
        chk(1, usb_port_route_pkg::OWN_NONE, 1'b0);
        // OTG transmit waits for a link clock rise
        otg_v = 1'b1;
        otg_d = 8'(rnd());
        for (int i = 0; i < 40 && otg_out.data_oe_b !== 1'b0; i++)
            step(1);
        cmp("otg tx oe", 8'h00, 8'(otg_out.data_oe_b));
        cmp("otg tx", otg_d, otg_out.data);
        // Wait ran out: already counted above, go straight to the verdict
        if (otg_out.data_oe_b !== 1'b0)
            end_sim();
        // OTG receive from the transceiver
        repeat (4)
        begin
            b = rnd();
            rx_q.push_back(b[7:0]);
            phy.send(b[7:0]);
            for (int i = 0; i < 40 && rx_q.size() != 0; i++)
                step(1);
            if (rx_q.size() != 0)
            begin
                mismatches++;
                end_sim();
            end
        end
        step(4);
        end_sim();
    end
endmodule : tb
`default_nettype wire
